// ---- host_index_model.sv ----
/* Host side index pulser for back-EMF start.
   Assumes start is a one-cycle request from the bench. */
`timescale 1ns/10ps
module host_index_model (
  input wire sys_clk,
  input wire start,
  input wire [3:0] count,
  output logic aux_index_input
);
  logic [3:0] left = 4'h0;
  initial aux_index_input = 1'b0;
  // One pulse per two cycles, each pulse advances commutation
  always @(posedge sys_clk) begin
    if (left != 4'h0) begin
      aux_index_input <= ~aux_index_input;
      if (aux_index_input) left <= left - 4'h1;
    end else if (start) left <= count;
  end
endmodule // host_index_model

// ---- tb_vcm_spindle_drive_control.sv ----
/* Self-checking bench: AHB-Lite master, queue of expected values.
   Assumes the checker and host index model are compiled first. */
`timescale 1ns/10ps
module tb_vcm_spindle_drive_control;
  logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic power_on_reset_n = 1'b1, hall_in_u = 1'b0, hall_in_v = 1'b0;
  logic hall_in_w = 1'b0, phase_above_hi = 1'b0, phase_below_lo = 1'b0;
  logic go = 1'b0, rd_phase = 1'b0, obs = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, obs_val = 32'h0, r;
  logic [31:0] seed = 32'h7C0D9E17;
  logic [31:0] exp_q[$];
  logic [2:0] hall_lut[6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int n_mismatch = 0, tests_run = 0, i;
  wire clk_en = 1'b1;
  wire hready, hreadyout, hresp, aux_index_input;
  wire [31:0] hrdata;
  wire [7:0] coil_dac_code, spindle_start_code;
  wire [2:0] gain_switch, spin_high, low_side_driver;
  wire coil_out_a_hi, coil_out_a_lo, coil_out_b_hi, coil_out_b_lo;
  wire retract_output, bias_enable, sleep_mode, center_tap_control;
  wire center_tap_control_oe, phase_cross_signal;
  assign hready = hreadyout;
  vcm_spindle_drive_control #(.RETRACT_CYCLES(8))
    vcm_spindle_drive_control_inst (.*);
  host_index_model host_index_model_inst (.sys_clk, .start(go),
    .count(4'h3), .aux_index_input);
  initial forever #20 sys_clk = ~sys_clk;
  task check(input [31:0] seen, input [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  always @(posedge sys_clk) begin
    if (rd_phase && hreadyout) check(hrdata, exp_q.pop_front());
    if (obs) check(obs_val, exp_q.pop_front());
  end
  // Read expectations ride in d; reads see data ahead of the second edge
  task bus(input logic w, input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !w;
    if (!w) exp_q.push_back(d);
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask
  task settle;
    @(posedge sys_clk);
    #1;
  endtask
  task see(input [31:0] v, input [31:0] e);
    exp_q.push_back(e);
    obs_val <= v;
    obs <= 1'b1;
    @(posedge sys_clk);
    obs <= 1'b0;
    #1;
  endtask
  task give_verdict;
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(0, 8'h00, 32'h80);
    bus(0, 8'h04, 32'h20);
    bus(1, 8'h04, 32'h0);
    for (i = 0; i < 4; i++) begin
      r = ($random(seed) & 32'hFF) | (i << 8);
      bus(1, 8'h00, r);
      settle;
      see(32'(coil_dac_code), r & 32'hFF);
      see(32'(spindle_start_code), 0);
      i = {r[8], r[9]};
      see(32'(gain_switch), i == 0 ? 0 : 1 << (i - 1));
      i = r[9:8];
    end
    $display("gain test done");
    bus(1, 8'h04, 32'h20);
    r = $random(seed) & 32'hFF;
    bus(1, 8'h00, r);
    settle;
    see(32'(spindle_start_code), r);
    see(32'(coil_dac_code), 32'h80);
    for (i = 1; i <= 7; i++) begin
      bus(1, 8'h04, 32'h30);
      bus(1, 8'h04, 32'h20);
      bus(0, 8'h0C, (i % 6) << 4);
    end
    $display("soft step test done");
    bus(1, 8'h04, 32'hA0);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (12) @(posedge sys_clk);
    bus(0, 8'h0C, 32'h40);
    bus(1, 8'h04, 32'h0);
    phase_above_hi <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    see(32'(phase_cross_signal), 1);
    @(posedge sys_clk);
    phase_above_hi <= 1'b0;
    phase_below_lo <= 1'b1;
    repeat (3) @(posedge sys_clk);
    phase_below_lo <= 1'b0;
    bus(0, 8'h0C, 32'h0);
    $display("index and phase test done");
    bus(1, 8'h04, 32'h40);
    for (i = 0; i < 6; i++) begin
      {hall_in_w, hall_in_v, hall_in_u} <= hall_lut[i];
      repeat (3) @(posedge sys_clk);
      bus(0, 8'h0C, 32'h1 | (i << 4));
    end
    $display("hall test done");
    bus(1, 8'h04, 32'h200);
    settle;
    see(32'({spin_high, low_side_driver}), 32'h38);
    bus(1, 8'h04, 32'h100);
    settle;
    see(32'({center_tap_control_oe, spin_high}), 32'h8);
    bus(1, 8'h08, 32'h1);
    settle;
    see(32'({coil_out_a_hi, coil_out_a_lo, coil_out_b_hi, coil_out_b_lo}),
      0);
    $display("drive mode test done");
    @(posedge sys_clk);
    power_on_reset_n <= 1'b0;
    bus(1, 8'h00, 32'h5A);
    settle;
    see(32'(retract_output), 1);
    see(32'({coil_out_b_hi, coil_out_b_lo}), 1);
    see(32'(bias_enable), 0);
    repeat (12) @(posedge sys_clk);
    #1;
    see(32'(retract_output), 0);
    bus(1, 8'h08, 32'h2);
    settle;
    see(32'(sleep_mode), 1);
    @(posedge sys_clk);
    power_on_reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus(0, 8'h00, 32'h80);
    $display("fault test done");
    give_verdict;
  end
endmodule // tb_vcm_spindle_drive_control

// ---- vcm_spindle_defines.vh ----
/*
 * Shared constants for the actuator and spindle control logic: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef VCM_SPINDLE_DEFINES_VH
`define VCM_SPINDLE_DEFINES_VH

`define OFS_PORT_A 8'h00
`define OFS_PORT_C 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0C

`define PA_DAC_LSB 0
`define PA_DAC_MSB 7
`define PA_GAIN_A 8
`define PA_GAIN_B 9

`define PC_SOFT_SOFT_COMMUTATE_BIT 4
`define PC_START_SEL 5
`define PC_HALL_MODE 6
`define PC_AUX_INDEX 7
`define PC_UNIPOLAR 8
`define PC_BRAKE 9

`define CT_VCM_DISABLE 0
`define CT_SLEEP 1
`define CT_VCM_IN_START 2

`define PORT_A_RESET 10'h080
`define PORT_C_RESET 10'h020
`define CTRL_RESET 3'h0

`define RETRACT_TIME_NS 6000000
`define CLK_PERIOD_NS 40
`define RETRACT_CYCLES (`RETRACT_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- vcm_spindle_drive_control.v ----
/*
 * Digital control for the voice-coil current command, fault retract,
 * spindle braking and spindle commutation, with an AHB-Lite register slave.
 * Assumes one clock, synchronous inputs and a single AHB-Lite master.
 */
`timescale 1ns/10ps
`include "vcm_spindle_defines.vh"

// Summary of operation
// - Port A bits 0-7 hold the 8-bit coil current code.
// - Port A bits 8 and 9 pick one of four gain ranges.
// - Gain codes 00/01/10/11 give 0.250/0.333/0.500/1.000, one switch max.
// - Code is offset binary: FF positive full scale, 00 negative.
// - Start mode sends the code to spindle start; run mode to the coil.
// - Any fault disables all voice-coil drivers except the coil B low side.
// - Coil output disable and sleep mode, sleep only after retract.
// - Voltage monitor fault enters retract mode.
// - Retract first resets control logic and disables bias and outputs.
// - Retract holds coil B low side on, B high side and coil A off.
// - Retract finally enables the retract output driver.
// - Unipolar mode drops spindle high sides and drives center-tap control; with brake also set, the code turns all high sides on.
// - Any fault disables all spindle drivers.
// - Braking turns spindle low sides off and high sides on.
// - A port C bit chooses Hall or back-EMF commutation.
// - Hall mode takes the state from three Hall inputs, no host needed.
// - With DAC starting the spindle, coil driver stays off during start unless control bit 2 is set.
// - In back-EMF mode, each 1-to-0 change of port C bit 4 advances one state.
// - Back-EMF run mode advances on either edge of the phase signal.
// - The phase signal toggles on reference crossings with hysteresis.
// - Port C bit 5: 1 is start mode, 0 is run mode.
// - Power-on-reset line low counts as fault and starts retract.
module vcm_spindle_drive_control #(
  parameter RETRACT_CYCLES = `RETRACT_CYCLES
) (
  input wire sys_clk,
  input wire nrst,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire power_on_reset_n,
  input wire hall_in_u,
  input wire hall_in_v,
  input wire hall_in_w,
  input wire aux_index_input,
  input wire phase_above_hi,
  input wire phase_below_lo,
  output reg [7:0] coil_dac_code,
  output reg [7:0] spindle_start_code,
  output reg [2:0] gain_switch,
  output reg coil_out_a_hi,
  output reg coil_out_a_lo,
  output reg coil_out_b_hi,
  output reg coil_out_b_lo,
  output reg retract_output,
  output reg bias_enable,
  output reg sleep_mode,
  output reg [2:0] spin_high,
  output reg [2:0] low_side_driver,
  output reg center_tap_control,
  output reg center_tap_control_oe,
  output reg phase_cross_signal
);

  localparam ST_RUN = 3'b001;
  localparam ST_RETRACT = 3'b010;
  localparam ST_PARKED = 3'b100;

  reg [9:0] port_a;
  reg [9:0] port_c;
  reg [2:0] ctrl;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] retract_count;
  reg [2:0] soft_commutate_bit_step;
  reg soft_commutate_bit_prev;
  reg aux_prev;
  reg phase_prev;
  reg ph_valid;
  reg ap_write;
  reg [7:0] ap_addr;
  reg [2:0] next_soft_commutate_bit_step;
  reg [2:0] next_ctrl;
  reg [31:0] next_rdata;
  reg next_phase;
  reg [3:0] next_coil;
  reg [5:0] next_spin;
  wire fault;
  wire retracting;
  wire start_mode;
  wire hall_mode;
  wire advance;
  wire [2:0] hall_step;
  wire addr_phase;
  wire ctrl_write;
  wire in_retract;
  wire parked;
  wire [5:0] drive_word;

  // Six-state inverter table: high side phase and low side phase
  function [5:0] step_drive;
    input [2:0] st;
    begin
      case (st)
        3'h0: step_drive = 6'b001_010;
        3'h1: step_drive = 6'b001_100;
        3'h2: step_drive = 6'b010_100;
        3'h3: step_drive = 6'b010_001;
        3'h4: step_drive = 6'b100_001;
        3'h5: step_drive = 6'b100_010;
        default: step_drive = 6'b000_000;
      endcase
    end
  endfunction

  function [2:0] hall_decode;
    input [2:0] h;
    begin
      case (h)
        3'b001: hall_decode = 3'h0;
        3'b011: hall_decode = 3'h1;
        3'b010: hall_decode = 3'h2;
        3'b110: hall_decode = 3'h3;
        3'b100: hall_decode = 3'h4;
        3'b101: hall_decode = 3'h5;
        default: hall_decode = 3'h7;
      endcase
    end
  endfunction

  assign fault = ~power_on_reset_n;
  assign retracting = fault | (state != ST_RUN);
  assign start_mode = port_c[`PC_START_SEL];
  assign hall_mode = port_c[`PC_HALL_MODE];
  assign hall_step = hall_decode({hall_in_w, hall_in_v, hall_in_u});
  // Zero wait states: every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign ctrl_write = ap_write & (ap_addr == `OFS_CTRL);
  assign in_retract = (state == ST_RETRACT);
  assign parked = (state == ST_PARKED);
  assign drive_word = step_drive(soft_commutate_bit_step);

  // Back-EMF advance sources: soft bit, aux pulse in start, phase in run
  assign advance = ~hall_mode & (
    (soft_commutate_bit_prev & ~port_c[`PC_SOFT_SOFT_COMMUTATE_BIT]) |
    (start_mode & port_c[`PC_AUX_INDEX] & aux_index_input & ~aux_prev) |
    (~start_mode & ph_valid & (phase_cross_signal != phase_prev)));

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: if (fault) next_state = ST_RETRACT;
      ST_RETRACT: if (retract_count >= RETRACT_CYCLES - 1)
        next_state = ST_PARKED;
      ST_PARKED: if (!fault) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // Hysteresis: a clear high sets, a clear low clears, both or neither holds
  always @* begin
    next_phase = phase_cross_signal;
    if (phase_above_hi & ~phase_below_lo)
      next_phase = 1'b1;
    else if (phase_below_lo & ~phase_above_hi)
      next_phase = 1'b0;
  end

  // Next inverter step; a fault parks the inverter at step 0
  always @* begin
    next_soft_commutate_bit_step = soft_commutate_bit_step;
    if (fault)
      next_soft_commutate_bit_step = 3'h0;
    else if (hall_mode) begin
      if (hall_step != 3'h7)
        next_soft_commutate_bit_step = hall_step;
    end else if (advance)
      next_soft_commutate_bit_step = (soft_commutate_bit_step == 3'h5) ? 3'h0 :
        soft_commutate_bit_step + 3'h1;
  end

  // Sleep request still taken once parked, else sleep could never be set
  always @* begin
    next_ctrl = `CTRL_RESET;
    if (parked)
      next_ctrl = ctrl_write ? hwdata[2:0] : ctrl;
  end

  // Read data for the access now in its address phase
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      `OFS_PORT_A: next_rdata = {22'h000000, port_a};
      `OFS_PORT_C: next_rdata = {22'h000000, port_c};
      `OFS_CTRL: next_rdata = {29'h00000000, ctrl};
      `OFS_STATUS: begin
        next_rdata[0] = hall_mode;
        next_rdata[1] = fault;
        next_rdata[2] = state[1];
        next_rdata[3] = state[2];
        next_rdata[6:4] = soft_commutate_bit_step;
        next_rdata[7] = phase_cross_signal;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus access; ports A and C fall back to power-up values on a fault, ctrl keeps writes once parked
  always @(posedge sys_clk) begin
    if (!nrst) begin
      port_a <= `PORT_A_RESET;
      port_c <= `PORT_C_RESET;
      ctrl <= `CTRL_RESET;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      // Address phase is latched for the write in the data phase
      ap_write <= addr_phase & hwrite;
      ap_addr <= haddr[7:0];
      if (fault) begin
        port_a <= `PORT_A_RESET;
        port_c <= `PORT_C_RESET;
        ctrl <= next_ctrl;
      end else if (ap_write) begin
        case (ap_addr)
          `OFS_PORT_A: port_a <= hwdata[9:0];
          `OFS_PORT_C: port_c <= hwdata[9:0];
          `OFS_CTRL: ctrl <= hwdata[2:0];
          default: ;
        endcase
      end
      if (addr_phase & ~hwrite)
        hrdata <= next_rdata;
    end
  end

  // Retract sequencing: a fixed dwell in retract before parking
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_RUN;
      retract_count <= 32'h0000_0000;
    end else if (clk_en) begin
      state <= next_state;
      if (in_retract)
        retract_count <= retract_count + 32'h0000_0001;
      else
        retract_count <= 32'h0000_0000;
    end
  end

  // Edge history for the three advance sources
  always @(posedge sys_clk) begin
    if (!nrst) begin
      soft_commutate_bit_prev <= 1'b0;
      aux_prev <= 1'b0;
      phase_prev <= 1'b0;
      ph_valid <= 1'b0;
    end else if (clk_en) begin
      soft_commutate_bit_prev <= port_c[`PC_SOFT_SOFT_COMMUTATE_BIT];
      aux_prev <= aux_index_input;
      phase_prev <= phase_cross_signal;
      ph_valid <= 1'b1;
    end
  end

  // Phase comparator and inverter step
  always @(posedge sys_clk) begin
    if (!nrst) begin
      phase_cross_signal <= 1'b0;
      soft_commutate_bit_step <= 3'h0;
    end else if (clk_en) begin
      phase_cross_signal <= next_phase;
      soft_commutate_bit_step <= next_soft_commutate_bit_step;
    end
  end

  // Coil bridge gates {a_hi, a_lo, b_hi, b_lo}; retract wins over all
  always @* begin
    next_coil = 4'b0000;
    if (retracting)
      next_coil = 4'b0001;
    else if (ctrl[`CT_VCM_DISABLE] | sleep_mode |
        (start_mode & ~ctrl[`CT_VCM_IN_START]))
      next_coil = 4'b0000;
    // Drive direction follows the code's sign bit
    else if (port_a[`PA_DAC_MSB])
      next_coil = 4'b1001;
    else
      next_coil = 4'b0110;
  end

  // Spindle gates: brake shorts the windings through the high sides
  always @* begin
    next_spin = 6'b000_000;
    if (retracting)
      next_spin = 6'b000_000;
    else if (port_c[`PC_BRAKE])
      next_spin = 6'b111_000;
    // Unipolar: the external transistor feeds the center tap instead
    else if (port_c[`PC_UNIPOLAR])
      next_spin = {3'b000, drive_word[2:0]};
    else
      next_spin = drive_word;
  end

  // Converter code and gain range
  always @(posedge sys_clk) begin
    if (!nrst) begin
      coil_dac_code <= 8'h80;
      spindle_start_code <= 8'h00;
      gain_switch <= 3'b000;
    end else if (clk_en) begin
      // Offset binary code passes straight to the converter
      coil_dac_code <= start_mode ? 8'h80 : port_a[7:0];
      spindle_start_code <= start_mode ? port_a[7:0] : 8'h00;
      case ({port_a[`PA_GAIN_A], port_a[`PA_GAIN_B]})
        2'b00: gain_switch <= 3'b000;
        2'b01: gain_switch <= 3'b001;
        2'b10: gain_switch <= 3'b010;
        default: gain_switch <= 3'b100;
      endcase
    end
  end

  // Bridge, retract driver, bias and sleep
  always @(posedge sys_clk) begin
    if (!nrst) begin
      coil_out_a_hi <= 1'b0;
      coil_out_a_lo <= 1'b0;
      coil_out_b_hi <= 1'b0;
      coil_out_b_lo <= 1'b0;
      retract_output <= 1'b0;
      bias_enable <= 1'b0;
      sleep_mode <= 1'b0;
    end else if (clk_en) begin
      coil_out_a_hi <= next_coil[3];
      coil_out_a_lo <= next_coil[2];
      coil_out_b_hi <= next_coil[1];
      coil_out_b_lo <= next_coil[0];
      retract_output <= retracting & in_retract;
      bias_enable <= ~retracting;
      sleep_mode <= parked & ctrl[`CT_SLEEP];
    end
  end

  // Spindle gates and the open-drain center-tap pull
  always @(posedge sys_clk) begin
    if (!nrst) begin
      spin_high <= 3'b000;
      low_side_driver <= 3'b000;
      center_tap_control <= 1'b0;
      center_tap_control_oe <= 1'b0;
    end else if (clk_en) begin
      spin_high <= next_spin[5:3];
      low_side_driver <= next_spin[2:0];
      // Open drain: only ever pulls low, released outside unipolar
      center_tap_control <= 1'b0;
      center_tap_control_oe <= ~retracting & port_c[`PC_UNIPOLAR];
    end
  end

endmodule // vcm_spindle_drive_control

// ---- vcm_spindle_sva.sv ----
/* Port checker for the drive control block.
   Assumes one clock domain and the bind at the foot. */
`timescale 1ns/10ps
module vcm_spindle_sva (
  input wire sys_clk,
  input wire nrst,
  input wire power_on_reset_n,
  input wire [2:0] gain_switch,
  input wire coil_out_a_hi,
  input wire coil_out_a_lo,
  input wire coil_out_b_hi,
  input wire coil_out_b_lo,
  input wire retract_output,
  input wire bias_enable,
  input wire [2:0] spin_high,
  input wire [2:0] low_side_driver,
  input wire center_tap_control_oe,
  input wire sleep_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_fault_coil_off: assert property (
    !power_on_reset_n |=> !coil_out_a_hi && !coil_out_a_lo && !coil_out_b_hi)
    else $error("coil driven in fault");
  a_fault_spin_off: assert property (
    !power_on_reset_n |=> spin_high == 3'h0 && low_side_driver == 3'h0)
    else $error("spindle driven in fault");
  a_fault_no_bias: assert property (
    !power_on_reset_n |=> !bias_enable) else $error("bias on in fault");
  a_retract_entry: assert property (
    $fell(power_on_reset_n) |-> ##[1:3] retract_output)
    else $error("no retract after fault");
  a_retract_coil: assert property (
    retract_output |-> coil_out_b_lo && !coil_out_b_hi
      && !coil_out_a_hi && !coil_out_a_lo) else $error("bad retract drive");
  a_gain_one_hot: assert property (
    $onehot0(gain_switch)) else $error("two gain switches");
  a_brake_lows: assert property (
    spin_high == 3'h7 |-> low_side_driver == 3'h0)
    else $error("low side on while braking");
  a_unipolar_high: assert property (
    center_tap_control_oe |-> spin_high == 3'h0)
    else $error("high side on in unipolar");
  a_sleep_parked: assert property (
    sleep_mode |-> !bias_enable && !retract_output)
    else $error("sleep outside parked");
endmodule // vcm_spindle_sva

bind vcm_spindle_drive_control vcm_spindle_sva vcm_spindle_sva_inst (.*);
